// ===== core/ocs_consts.vh
// Constants for the oscillator watchdog and clock select block.
// Included by every design file of the block; definitions only.
`ifndef OCS_CONSTS_VH
`define OCS_CONSTS_VH

// Bit of the system configuration word that disables the watchdog
`define OCS_WD_DIS_BIT     4

// Watchdog counter: overflow after this many PLL clocks
`define OCS_WD_W           5
`define OCS_WD_OVF         5'h10

// Clock select strap codes
`define OCS_STRAP_X16      3'h0
`define OCS_STRAP_PRESC    3'h1
`define OCS_STRAP_X10      3'h2
`define OCS_STRAP_DIRECT   3'h3
`define OCS_STRAP_X5       3'h4
`define OCS_STRAP_X8       3'h5
`define OCS_STRAP_X3       3'h6
`define OCS_STRAP_X4       3'h7
`define OCS_STRAP_RST      3'h7

// PLL settings: input divider, VCO multiplier, output divider
`define OCS_IDIV_4         3'h4
`define OCS_IDIV_2         3'h2
`define OCS_MUL_64         7'h40
`define OCS_MUL_48         7'h30
`define OCS_MUL_40         7'h28
`define OCS_ODIV_4         3'h4
`define OCS_ODIV_2         3'h2

// Free-running PLL clock half period, in system clock cycles
`define OCS_FREE_HALF      4'h4

// Width of the input period measurement
`define OCS_PER_W          16

`endif

// ===== core/ocs_freerun.v
// Free-running PLL oscillator model: a divided level and a rising tick.
// Assumes the parent gates it with the PLL power enable.
`timescale 1ns/10ps
`include "ocs_consts.vh"
module ocs_freerun
(
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_b_i,
	input  wire       ce_i,
	// Control
	input  wire       en_i,
	// Outputs
	output reg        lvl_o,
	output reg        tick_o
);
	reg [3:0] half_cnt_r;

	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			half_cnt_r <= 4'h0;
			lvl_o      <= 1'b0;
			tick_o     <= 1'b0;
		end
		else if (ce_i)
		begin
			tick_o <= 1'b0;
			if (!en_i)
			begin
				// Powered off: hold low so a later start has no runt
				half_cnt_r <= 4'h0;
				lvl_o      <= 1'b0;
			end
			else if (half_cnt_r == `OCS_FREE_HALF - 4'h1)
			begin
				half_cnt_r <= 4'h0;
				lvl_o      <= ~lvl_o;
				tick_o     <= ~lvl_o;
			end
			else
				half_cnt_r <= half_cnt_r + 4'h1;
		end
	end
endmodule

// ===== core/ocs_wdog.v
// Oscillator watchdog counter: counts PLL ticks, cleared by input edges.
// Assumes tick and edge are one-cycle pulses on the same clock.
`timescale 1ns/10ps
`include "ocs_consts.vh"
module ocs_wdog
(
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_b_i,
	input  wire       ce_i,
	// Control
	input  wire       en_i,
	input  wire       pll_tick_i,
	input  wire       xtal_edge_i,
	// Result
	output reg        ovf_o
);
	reg [`OCS_WD_W-1:0] cnt_r;

	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cnt_r <= {`OCS_WD_W{1'b0}};
			ovf_o <= 1'b0;
		end
		else if (ce_i)
		begin
			ovf_o <= 1'b0;
			// An input edge beats a tick in the same cycle
			if (!en_i || xtal_edge_i)
				cnt_r <= {`OCS_WD_W{1'b0}};
			else if (pll_tick_i && cnt_r != `OCS_WD_OVF)
			begin
				cnt_r <= cnt_r + {{(`OCS_WD_W-1){1'b0}}, 1'b1};
				if (cnt_r == `OCS_WD_OVF - {{(`OCS_WD_W-1){1'b0}}, 1'b1})
					ovf_o <= 1'b1;
			end
		end
	end
endmodule

// ===== core/ocs_top.v
// Clock select and oscillator watchdog: strap decode, PLL model,
// watchdog failover to the free-running clock.
// Assumes the crystal input and straps are asynchronous pins; the
// system configuration word and interrupt clear are on clk_i.
`timescale 1ns/10ps
`include "ocs_consts.vh"
module ocs_top
(
	// Clock, reset, enable
	input  wire        clk_i,
	input  wire        rst_b_i,
	input  wire        ce_i,
	// Pins
	input  wire        crystal_input_pin_i,
	input  wire [2:0]  clock_select_straps_i,
	// System side
	input  wire [15:0] system_config_register_i,
	input  wire        wd_irq_clr_i,
	// Clock outputs
	output reg         cpu_clk_o,
	output reg         clk_src_free_o,
	output reg         pll_power_o,
	output reg         osc_amp_bypass_o,
	// Status
	output reg         wd_irq_o,
	output reg  [2:0]  clk_mode_o,
	output reg  [4:0]  pll_factor_o,
	output reg  [2:0]  pll_in_div_o,
	output reg  [6:0]  vco_mult_o,
	output reg  [2:0]  pll_out_div_o
);
	// Pin synchronisers; no reset so straps are tracked during reset
	reg [2:0] strap_s1_r;
	reg [2:0] strap_s2_r;
	reg       xtal_s1_r;
	reg       xtal_s2_r;
	reg       xtal_d_r;

	always @(posedge clk_i)
	begin
		if (ce_i)
		begin
			strap_s1_r <= clock_select_straps_i;
			strap_s2_r <= strap_s1_r;
			xtal_s1_r  <= crystal_input_pin_i;
			xtal_s2_r  <= xtal_s1_r;
			xtal_d_r   <= xtal_s2_r;
		end
	end

	wire xtal_edge = xtal_s2_r ^ xtal_d_r;
	wire xtal_rise = xtal_s2_r & ~xtal_d_r;

	// Strap capture on the first enabled edge after reset release
	reg       strap_done_r;
	reg [2:0] mode_r;

	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			strap_done_r <= 1'b0;
			mode_r       <= `OCS_STRAP_RST;
		end
		else if (ce_i && !strap_done_r)
		begin
			strap_done_r <= 1'b1;
			mode_r       <= strap_s2_r;
		end
	end

	wire mode_direct = (mode_r == `OCS_STRAP_DIRECT);
	wire mode_presc  = (mode_r == `OCS_STRAP_PRESC);
	wire mode_bypass = mode_direct | mode_presc;
	wire mode_pll    = strap_done_r & ~mode_bypass;

	// Strap decode of the PLL divider chain
	reg [2:0] idiv_nxt;
	reg [6:0] mul_nxt;
	reg [2:0] odiv_nxt;
	reg [4:0] fac_nxt;

	always @*
	begin
		idiv_nxt = `OCS_IDIV_4;
		mul_nxt  = `OCS_MUL_64;
		odiv_nxt = `OCS_ODIV_4;
		fac_nxt  = 5'h04;
		case (mode_r)
			`OCS_STRAP_X4:
			begin
				fac_nxt = 5'h04;
			end
			`OCS_STRAP_X3:
			begin
				mul_nxt = `OCS_MUL_48;
				fac_nxt = 5'h03;
			end
			`OCS_STRAP_X8:
			begin
				odiv_nxt = `OCS_ODIV_2;
				fac_nxt  = 5'h08;
			end
			`OCS_STRAP_X5:
			begin
				mul_nxt  = `OCS_MUL_40;
				odiv_nxt = `OCS_ODIV_2;
				fac_nxt  = 5'h05;
			end
			`OCS_STRAP_X10:
			begin
				idiv_nxt = `OCS_IDIV_2;
				mul_nxt  = `OCS_MUL_40;
				odiv_nxt = `OCS_ODIV_2;
				fac_nxt  = 5'h0A;
			end
			`OCS_STRAP_X16:
			begin
				idiv_nxt = `OCS_IDIV_2;
				odiv_nxt = `OCS_ODIV_2;
				fac_nxt  = 5'h10;
			end
			`OCS_STRAP_DIRECT,
			`OCS_STRAP_PRESC:
			begin
				// PLL bypassed: chain unused
				idiv_nxt = 3'h0;
				mul_nxt  = 7'h00;
				odiv_nxt = 3'h0;
				fac_nxt  = 5'h01;
			end
			default:
			begin
				fac_nxt = 5'h04;
			end
		endcase
	end

	// Watchdog enable and PLL power
	wire wd_dis     = system_config_register_i[`OCS_WD_DIS_BIT];
	wire wd_active  = strap_done_r & mode_bypass & ~wd_dis;
	reg  fail_r;
	reg  src_free_r;
	wire pll_on     = mode_pll | wd_active | fail_r;

	wire free_lvl;
	wire free_tick;
	wire wd_ovf;

	ocs_freerun u_freerun
	(
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.ce_i    (ce_i),
		.en_i    (pll_on),
		.lvl_o   (free_lvl),
		.tick_o  (free_tick)
	);

	ocs_wdog u_wdog
	(
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.ce_i        (ce_i),
		.en_i        (wd_active & ~fail_r),
		.pll_tick_i  (free_tick),
		.xtal_edge_i (xtal_edge),
		.ovf_o       (wd_ovf)
	);

	// PLL model: period measured per input cycle, phase accumulator
	// makes 2F toggles per input period. Reference taken only every
	// F input transitions; taken whole at first lock, then approached by halves.
	reg [`OCS_PER_W-1:0] per_cnt_r;
	reg [`OCS_PER_W-1:0] per_meas_r;
	reg [`OCS_PER_W-1:0] per_use_r;
	reg [`OCS_PER_W-1:0] acc_r;
	reg [4:0]            sync_cnt_r;
	reg                  pll_lvl_r;

	wire [`OCS_PER_W-1:0] step  = {{(`OCS_PER_W-6){1'b0}}, fac_nxt, 1'b0};
	wire [`OCS_PER_W-1:0] acc_s = acc_r + step;
	wire [`OCS_PER_W-1:0] diff  = per_meas_r - per_use_r;
	wire [`OCS_PER_W-1:0] half  = {diff[`OCS_PER_W-1], diff[`OCS_PER_W-1:1]};

	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			per_cnt_r  <= {`OCS_PER_W{1'b0}};
			per_meas_r <= {`OCS_PER_W{1'b0}};
			per_use_r  <= {`OCS_PER_W{1'b0}};
			acc_r      <= {`OCS_PER_W{1'b0}};
			sync_cnt_r <= 5'h00;
			pll_lvl_r  <= 1'b0;
		end
		else if (ce_i && mode_pll)
		begin
			if (xtal_rise)
			begin
				per_cnt_r  <= {`OCS_PER_W{1'b0}};
				per_meas_r <= per_cnt_r + {{(`OCS_PER_W-1){1'b0}}, 1'b1};
			end
			else if (per_cnt_r != {`OCS_PER_W{1'b1}})
				per_cnt_r <= per_cnt_r + {{(`OCS_PER_W-1){1'b0}}, 1'b1};
			if (xtal_edge)
			begin
				if (sync_cnt_r >= fac_nxt - 5'h01)
				begin
					sync_cnt_r <= 5'h00;
					// First lock takes the figure; later ones step by halves
					if (per_use_r == {`OCS_PER_W{1'b0}})
						per_use_r <= per_meas_r;
					else if (diff != {`OCS_PER_W{1'b0}})
						per_use_r <= per_use_r + ((half == {`OCS_PER_W{1'b0}})
							? diff : half);
				end
				else
					sync_cnt_r <= sync_cnt_r + 5'h01;
			end
			if (per_use_r != {`OCS_PER_W{1'b0}})
			begin
				if (acc_s >= per_use_r)
				begin
					acc_r     <= acc_s - per_use_r;
					pll_lvl_r <= ~pll_lvl_r;
				end
				else
					acc_r <= acc_s;
			end
		end
	end

	// Failure latch and glitch-free source switch
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			fail_r     <= 1'b0;
			src_free_r <= 1'b0;
		end
		else if (ce_i)
		begin
			if (wd_ovf)
				fail_r <= 1'b1;
			// Change over only while both clocks sit low: no runt pulse
			if (fail_r && !src_free_r && !cpu_clk_o && !free_lvl)
				src_free_r <= 1'b1;
		end
	end

	// CPU clock generation
	reg cpu_clk_nxt;

	always @*
	begin
		cpu_clk_nxt = 1'b0;
		if (src_free_r)
			cpu_clk_nxt = free_lvl;
		else if (fail_r)
			cpu_clk_nxt = 1'b0;
		else if (!strap_done_r)
			cpu_clk_nxt = 1'b0;
		else if (mode_direct)
			cpu_clk_nxt = xtal_s2_r;
		else if (mode_presc)
			cpu_clk_nxt = xtal_rise ? ~cpu_clk_o : cpu_clk_o;
		else
			cpu_clk_nxt = pll_lvl_r;
	end

	// Registered outputs
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cpu_clk_o        <= 1'b0;
			clk_src_free_o   <= 1'b0;
			pll_power_o      <= 1'b0;
			osc_amp_bypass_o <= 1'b0;
			wd_irq_o         <= 1'b0;
			clk_mode_o       <= `OCS_STRAP_RST;
			pll_factor_o     <= 5'h00;
			pll_in_div_o     <= 3'h0;
			vco_mult_o       <= 7'h00;
			pll_out_div_o    <= 3'h0;
		end
		else if (ce_i)
		begin
			cpu_clk_o        <= cpu_clk_nxt;
			clk_src_free_o   <= src_free_r;
			pll_power_o      <= pll_on;
			osc_amp_bypass_o <= strap_done_r & mode_direct;
			// Set wins over a clear in the same cycle
			if (wd_ovf)
				wd_irq_o <= 1'b1;
			else if (wd_irq_clr_i)
				wd_irq_o <= 1'b0;
			clk_mode_o       <= mode_r;
			pll_factor_o     <= fac_nxt;
			pll_in_div_o     <= idiv_nxt;
			vco_mult_o       <= mul_nxt;
			pll_out_div_o    <= odiv_nxt;
		end
	end
endmodule

// ===== verif/ocs_xtal_model.sv
// Behavioural crystal on the clock input pin of the clock select block.
// Assumes the bench stops and restarts it through run_i.
`timescale 1ns/10ps
module ocs_xtal_model
#(
	// Toggles on falling clock edges only: never races a sampling edge.
	// Slow enough that the PLL model can fit 2F toggles per period.
	parameter HALF = 200
)
(
	// Control
	input  wire run_i,
	// Pin
	output reg  xtal_o
);
	// Scaled period; a stopped crystal just freezes at its last level
	initial xtal_o = 1'b0;
	always
	begin
		#HALF;
		if (run_i)
			xtal_o = ~xtal_o;
	end
endmodule

// ===== verif/ocs_top_properties.sv
// Checker for the clock select and oscillator watchdog block.
// Assumes ce_i stays high, so every edge is an enabled edge.
`timescale 1ns/10ps
module ocs_props
(
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic        ce_i,
	input wire logic        crystal_input_pin_i,
	input wire logic [2:0]  clock_select_straps_i,
	input wire logic [15:0] system_config_register_i,
	input wire logic        wd_irq_clr_i,
	input wire logic        cpu_clk_o,
	input wire logic        clk_src_free_o,
	input wire logic        pll_power_o,
	input wire logic        osc_amp_bypass_o,
	input wire logic        wd_irq_o,
	input wire logic [2:0]  clk_mode_o,
	input wire logic [4:0]  pll_factor_o,
	input wire logic [2:0]  pll_in_div_o,
	input wire logic [6:0]  vco_mult_o,
	input wire logic [2:0]  pll_out_div_o
);
	reg  [2:0]  cnt_r;
	reg  [7:0]  quiet_r;
	reg         xprev_r;
	reg  [12:0] dexp;
	wire        up = (cnt_r == 3'h7);
	wire        byp = (clk_mode_o == 3'h3) || (clk_mode_o == 3'h1);
	wire        cfg = system_config_register_i[4];
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// Quiet time measured on the raw pin, so it bounds the synced view
	always @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			cnt_r   <= 3'h0;
			quiet_r <= 8'h00;
			xprev_r <= 1'b0;
		end
		else
		begin
			cnt_r   <= up ? cnt_r : cnt_r + 3'h1;
			xprev_r <= crystal_input_pin_i;
			if (crystal_input_pin_i != xprev_r)
				quiet_r <= 8'h00;
			else if (quiet_r != 8'hFF)
				quiet_r <= quiet_r + 8'h01;
		end
	always @*
		case (clk_mode_o)
			3'h7: dexp = {3'h4, 7'h40, 3'h4};
			3'h6: dexp = {3'h4, 7'h30, 3'h4};
			3'h5: dexp = {3'h4, 7'h40, 3'h2};
			3'h4: dexp = {3'h4, 7'h28, 3'h2};
			3'h2: dexp = {3'h2, 7'h28, 3'h2};
			3'h0: dexp = {3'h2, 7'h40, 3'h2};
			default: dexp = 13'h0000;
		endcase
	a_mode_held: assert property (
		up |-> $stable(clk_mode_o)) else $error("strap mode changed");
	a_div_decode: assert property (
		up |-> {pll_in_div_o, vco_mult_o, pll_out_div_o} == dexp)
		else $error("divider settings wrong");
	a_amp_bypass: assert property (
		up |-> osc_amp_bypass_o == (clk_mode_o == 3'h3))
		else $error("amplifier bypass wrong");
	a_pll_on: assert property (
		up && !byp |-> pll_power_o) else $error("PLL off in PLL mode");
	a_pll_off: assert property (
		up && byp && cfg && $past(cfg) && !wd_irq_o && !clk_src_free_o
		|-> !pll_power_o) else $error("PLL on while watchdog off");
	a_src_sticky: assert property (
		clk_src_free_o |=> clk_src_free_o) else $error("free source dropped");
	a_fail_bypass: assert property (
		$rose(clk_src_free_o) |-> byp) else $error("failover in PLL mode");
	a_irq_switch: assert property (
		$rose(wd_irq_o) |-> ##[0:24] clk_src_free_o)
		else $error("no switch after flag");
	a_no_early: assert property (
		$rose(wd_irq_o) |-> quiet_r >= 8'h78) else $error("early failure");
	a_detect: assert property (
		up && byp && !cfg && quiet_r == 8'hA0 |-> wd_irq_o || clk_src_free_o)
		else $error("stopped clock not detected");
	a_direct: assert property (
		up && clk_mode_o == 3'h3 && !wd_irq_o && !clk_src_free_o
		|-> cpu_clk_o == $past(crystal_input_pin_i, 3))
		else $error("direct clock not followed");
	// Bypass and free clocks all have high phases of several cycles
	a_no_runt: assert property (
		byp && $rose(cpu_clk_o) |=> cpu_clk_o)
		else $error("runt CPU clock pulse");
	c_fail: cover property ($rose(clk_src_free_o));
	c_clear: cover property ($fell(wd_irq_o));
	c_presc_off: cover property (up && clk_mode_o == 3'h1 && cfg);
endmodule
bind ocs_top ocs_props ocs_props_i
(
	.clk_i                    (clk_i),
	.rst_b_i                  (rst_b_i),
	.ce_i                     (ce_i),
	.crystal_input_pin_i      (crystal_input_pin_i),
	.clock_select_straps_i    (clock_select_straps_i),
	.system_config_register_i (system_config_register_i),
	.wd_irq_clr_i             (wd_irq_clr_i),
	.cpu_clk_o                (cpu_clk_o),
	.clk_src_free_o           (clk_src_free_o),
	.pll_power_o              (pll_power_o),
	.osc_amp_bypass_o         (osc_amp_bypass_o),
	.wd_irq_o                 (wd_irq_o),
	.clk_mode_o               (clk_mode_o),
	.pll_factor_o             (pll_factor_o),
	.pll_in_div_o             (pll_in_div_o),
	.vco_mult_o               (vco_mult_o),
	.pll_out_div_o            (pll_out_div_o)
);

// ===== verif/tb_top.sv
// Testbench for the clock select and oscillator watchdog block.
// Assumes the crystal model and the bound checker are compiled first.
`timescale 1ns/10ps
module tb_top;
	localparam [39:0] FTAB = {5'h04, 5'h03, 5'h08, 5'h05,
		5'h01, 5'h0A, 5'h01, 5'h10};
	reg         clk_i = 1'b0;
	reg         rst_b_i = 1'b0;
	reg  [2:0]  straps = 3'h7;
	reg  [15:0] cfg = 16'h0000;
	reg         irq_clr = 1'b0;
	reg         run = 1'b1;
	wire        xtal;
	wire        cpu_clk;
	wire        src_free;
	wire        pll_pwr;
	wire        amp_byp;
	wire        irq;
	wire [2:0]  mode;
	wire [4:0]  fct;
	integer     error_cnt = 0;
	integer     cmp_count = 0;
	integer     cyc = 0;
	integer     xr = 0;
	integer     cr = 0;
	integer     i;
	ocs_xtal_model ocs_xtal_model_i (.run_i(run), .xtal_o(xtal));
	ocs_top ocs_top_i
	(
		.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
		.crystal_input_pin_i(xtal), .clock_select_straps_i(straps),
		.system_config_register_i(cfg), .wd_irq_clr_i(irq_clr),
		.cpu_clk_o(cpu_clk), .clk_src_free_o(src_free),
		.pll_power_o(pll_pwr), .osc_amp_bypass_o(amp_byp),
		.wd_irq_o(irq), .clk_mode_o(mode), .pll_factor_o(fct),
		.pll_in_div_o(), .vco_mult_o(), .pll_out_div_o()
	);
	always #5 clk_i = ~clk_i;
	always @(posedge xtal) xr = xr + 1;
	always @(posedge cpu_clk) cr = cr + 1;
	task check(input string nm, input logic [15:0] seen, exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Straps held well around release so the sync stages are full
	task do_reset(input [2:0] s, input [15:0] c);
		@(negedge clk_i);
		rst_b_i = 1'b0;
		straps = s;
		cfg = c;
		repeat (5) @(negedge clk_i);
		rst_b_i = 1'b1;
		repeat (4) @(negedge clk_i);
	endtask
	task t_decode;
		for (i = 0; i < 8; i = i + 1)
		begin
			do_reset(i[2:0], 16'h0000);
			straps = ~i[2:0];
			repeat (3) @(negedge clk_i);
			check("mode", mode, i[2:0]);
			check("factor", fct, FTAB[i*5 +: 5]);
			check("bypass", amp_byp, i == 3);
			check("pll power", pll_pwr, 1'b1);
		end
	endtask
	task t_failover;
		do_reset(3'h3, 16'h0000);
		repeat (300) @(negedge clk_i);
		check("irq running", irq, 1'b0);
		run = 1'b0;
		for (i = 0; i < 300 && irq !== 1'b1; i = i + 1) @(negedge clk_i);
		check("irq", irq, 1'b1);
		for (i = 0; i < 40 && src_free !== 1'b1; i = i + 1) @(negedge clk_i);
		check("free source", src_free, 1'b1);
		run = 1'b1;
		repeat (200) @(negedge clk_i);
		check("free sticky", src_free, 1'b1);
		irq_clr = 1'b1;
		@(negedge clk_i);
		irq_clr = 1'b0;
		@(negedge clk_i);
		check("irq cleared", irq, 1'b0);
		do_reset(3'h3, 16'h0000);
		check("free after reset", src_free, 1'b0);
	endtask
	task t_disabled;
		do_reset(3'h1, 16'h0010);
		check("pll off", pll_pwr, 1'b0);
		xr = 0;
		cr = 0;
		repeat (400) @(negedge clk_i);
		check("halved", (2*cr >= xr - 2) && (2*cr <= xr + 2), 1'b1);
		run = 1'b0;
		repeat (300) @(negedge clk_i);
		check("irq off", irq, 1'b0);
		check("no switch", src_free, 1'b0);
		run = 1'b1;
	endtask
	task t_pll;
		do_reset(3'h7, 16'h0000);
		// Period figure converges by halves; let it settle first
		repeat (1000) @(negedge clk_i);
		xr = 0;
		cr = 0;
		repeat (800) @(negedge clk_i);
		check("x4", (cr >= 4*xr - 4) && (cr <= 4*xr + 4), 1'b1);
		run = 1'b0;
		repeat (300) @(negedge clk_i);
		check("pll irq", irq, 1'b0);
		check("pll switch", src_free, 1'b0);
		run = 1'b1;
	endtask
	// Whole run needs about 4000 cycles
	always @(posedge clk_i)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt = error_cnt + 1;
			give_verdict;
		end
	end
	initial
	begin
		t_decode;
		t_failover;
		t_disabled;
		t_pll;
		give_verdict;
	end
endmodule
